// ===== logic/tps_pkg.sv
// Constants, types and template tables for the transmit pulse-shaping block
package tps_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SHAPE  = 8'h06;
    localparam logic [7:0] ADDR_SCALE  = 8'h07;
    localparam logic [7:0] ADDR_ACCESS = 8'h08;
    localparam logic [7:0] ADDR_DATA   = 8'h09;
    localparam logic [7:0] ADDR_MASK   = 8'h15;
    localparam logic [7:0] ADDR_STATUS = 8'h1a;

    // Field positions in the waveform access register
    localparam int ACC_TRIG_BIT = 7;
    localparam int ACC_DIR_BIT  = 6;
    localparam int ACC_UI_LSB   = 4;
    localparam int ACC_SUB_LSB  = 0;
    // Overflow bit in the mask and status registers
    localparam int OVF_BIT      = 0;

    // Template select codes
    localparam logic [3:0] PULSE_TEMPLATE_SELECT_75_INTERNAL = 4'h0;
    localparam logic [3:0] PULSE_TEMPLATE_SELECT_120_OR_EXT  = 4'h1;
    localparam logic [1:0] PULSE_TEMPLATE_SELECT_ARB_UPPER   = 2'h3;

    // Waveform geometry
    localparam int NUM_UI    = 4;
    localparam int NUM_SUB   = 16;
    localparam int RAM_DEPTH = NUM_UI * NUM_SUB;
    localparam int SAMPLE_W  = 7;

    // Amplitude limits and scaling
    localparam logic [5:0]         MAG_MAX     = 6'h3f;
    localparam logic signed [16:0] DAC_LIMIT   = 17'sh0_003f;
    localparam logic [5:0]         SCALE_RESET = 6'h1f;
    localparam int                 SCALE_SHIFT = 5;

    // Reset values
    localparam logic [3:0] SHAPE_RESET = PULSE_TEMPLATE_SELECT_75_INTERNAL;

    typedef enum logic {
        ST_IDLE,
        ST_ACCESS
    } tps_acc_state_type;

    // On-chip reference templates; nominal shape values, plain defaults
    function automatic logic [6:0] tps_rom_sample(input logic tmpl, input logic [5:0] idx);
        logic [6:0] v;
        v = 7'h00;
        if (idx[5:4] == 2'h0 && idx[3:0] >= 4'h2 && idx[3:0] <= 4'hb) begin
            v = tmpl ? 7'h3c : 7'h30;
        end else if (idx[5:4] == 2'h1 && idx[3:0] <= 4'h2) begin
            v = 7'h44;
        end
        return v;
    endfunction

endpackage

// ===== logic/tps_ram_if.sv
// Interface between the shaping control and the waveform sample RAM
`timescale 1ns/100ps
interface tps_ram_if;
    import tps_pkg::*;
    logic                              we;
    logic [5:0]                        addr;
    logic [SAMPLE_W-1:0]               wdata;
    logic [SAMPLE_W-1:0]               rdata;
    logic [3:0]                        phase;
    logic [NUM_UI-1:0][SAMPLE_W-1:0]   tap;

    modport ctrl (output we, output addr, output wdata, output phase, input rdata, input tap);
    modport mem  (input we, input addr, input wdata, input phase, output rdata, output tap);
endinterface

// ===== logic/tps_wave_ram.sv
// Waveform sample RAM with one access port and one tap per unit interval
`timescale 1ns/100ps
module tps_wave_ram
    import tps_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Control side
    tps_ram_if.mem   ram
);

    typedef struct packed {
        logic [RAM_DEPTH-1:0][SAMPLE_W-1:0] mem;
    } tps_ram_state_type;

    tps_ram_state_type r_reg;
    tps_ram_state_type r_next;

    always_comb begin
        r_next = r_reg;
        if (ram.we) begin
            r_next.mem[ram.addr] = ram.wdata;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign ram.rdata = r_reg.mem[ram.addr];

    // All four intervals are read at once so overlap can be summed
    for (genvar k = 0; k < NUM_UI; k++) begin : g_tap
        assign ram.tap[k] = r_reg.mem[{2'(k), ram.phase}];
    end

    property p_write_lands;
        @(posedge i_clk_sys) disable iff (i_rst)
        ram.we |=> r_reg.mem[$past(ram.addr)] == $past(ram.wdata);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("RAM write lost");

endmodule

// ===== logic/tps_pulse_shaper.sv
// Transmit pulse template selection, waveform RAM access and sample output
`timescale 1ns/100ps
module tps_pulse_shaper
    import tps_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    // Register port
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_rvalid,
    // Line symbol timing
    input  wire logic       i_ui_start,
    input  wire logic       i_sample_en,
    input  wire logic       i_mark_pos,
    input  wire logic       i_mark_neg,
    // Converter code and interrupt
    output logic      [6:0] o_dac_code,
    output logic            o_irq
);

    typedef struct packed {
        logic [3:0]              shape;
        logic [5:0]              scale;
        logic [1:0]              ui;
        logic [3:0]              sub;
        logic                    dir;
        logic                    trig;
        logic [6:0]              data;
        logic                    mask;
        logic                    ovf;
        tps_acc_state_type       st;
        logic [3:0]              phase;
        logic [NUM_UI-1:0][1:0]  hist;
        logic [6:0]              dac;
        logic                    irq;
        logic [7:0]              rdata;
        logic                    rvalid;
    } tps_state_type;

    tps_state_type r_reg;
    tps_state_type r_next;

    tps_ram_if ram_if ();

    logic                    arb;
    logic [6:0]              rom_val;
    logic signed [8:0]       contrib [NUM_UI];
    logic signed [8:0]       sum;
    logic [7:0]              scl;
    logic signed [16:0]      prod;
    logic signed [16:0]      level;
    logic signed [16:0]      abs_level;
    logic                    over;
    logic [6:0]              code;
    logic                    wr_access;

    tps_wave_ram u_ram (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .ram       (ram_if.mem)
    );

    assign arb = (r_reg.shape[3:2] == PULSE_TEMPLATE_SELECT_ARB_UPPER);

    // RAM is writable in any mode so a shape can be loaded before switching
    assign ram_if.we    = (r_reg.st == ST_ACCESS) && !r_reg.dir;
    assign ram_if.addr  = {r_reg.ui, r_reg.sub};
    assign ram_if.wdata = r_reg.data;
    assign ram_if.phase = r_reg.phase;

    // Preset reads return the reference template entry
    assign rom_val = tps_rom_sample(r_reg.shape[0], {r_reg.ui, r_reg.sub});

    // Each recent symbol weights the samples of its own interval
    for (genvar k = 0; k < NUM_UI; k++) begin : g_contrib
        logic [6:0]        s;
        logic signed [8:0] v;
        assign s = arb ? ram_if.tap[k] : tps_rom_sample(r_reg.shape[0], {2'(k), r_reg.phase});
        assign v = s[6] ? -$signed({3'h0, s[5:0]}) : $signed({3'h0, s[5:0]});
        assign contrib[k] = r_reg.hist[k][0] ? v : (r_reg.hist[k][1] ? -v : 9'sh000);
    end

    assign sum   = contrib[0] + contrib[1] + contrib[2] + contrib[3];
    assign scl   = {2'h0, r_reg.scale} + 8'h01;
    assign prod  = sum * $signed(scl);
    // Scaling applies only to the arbitrary shape
    // Both arms signed, else the shift turns logical
    assign level = arb ? (prod >>> SCALE_SHIFT) : $signed({{8{sum[8]}}, sum});
    assign over  = (level > DAC_LIMIT) || (level < -DAC_LIMIT);
    assign abs_level = level[16] ? -level : level;
    // Saturate so a bad shape clips rather than wraps
    assign code  = {level[16], over ? MAG_MAX : abs_level[5:0]};

    assign wr_access = i_reg_wr && (i_reg_addr == ADDR_ACCESS) && (r_reg.st == ST_IDLE);

    always_comb begin
        r_next = r_reg;

        // Register writes
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                ADDR_SHAPE: begin
                    r_next.shape = i_reg_wdata[3:0];
                end
                ADDR_SCALE: begin
                    r_next.scale = i_reg_wdata[5:0];
                end
                ADDR_DATA: begin
                    r_next.data = i_reg_wdata[6:0];
                end
                ADDR_MASK: begin
                    r_next.mask = i_reg_wdata[OVF_BIT];
                end
                default: begin
                end
            endcase
        end

        // Access register is locked while an access is in flight
        if (wr_access) begin
            r_next.ui   = i_reg_wdata[ACC_UI_LSB +: 2];
            r_next.sub  = i_reg_wdata[ACC_SUB_LSB +: 4];
            r_next.dir  = i_reg_wdata[ACC_DIR_BIT];
            r_next.trig = i_reg_wdata[ACC_TRIG_BIT];
        end

        unique case (r_reg.st)
            ST_IDLE: begin
                if (wr_access && i_reg_wdata[ACC_TRIG_BIT]) begin
                    r_next.st = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (r_reg.dir) begin
                    r_next.data = arb ? ram_if.rdata : rom_val;
                end
                r_next.trig = 1'h0;
                r_next.st   = ST_IDLE;
            end
        endcase

        // Output code, symbol history and sub-phase position
        if (i_sample_en) begin
            r_next.dac   = (code[5:0] == 6'h00) ? 7'h00 : code;
            r_next.phase = r_reg.phase + 4'h1;
        end
        if (i_ui_start) begin
            r_next.hist  = {r_reg.hist[NUM_UI-2:0], i_mark_neg, i_mark_pos};
            r_next.phase = 4'h0;
        end

        // Status clears on read; a new overflow in that cycle wins
        if (i_reg_rd && (i_reg_addr == ADDR_STATUS)) begin
            r_next.ovf = 1'h0;
        end
        if (i_sample_en && over) begin
            r_next.ovf = 1'h1;
        end

        r_next.irq = r_reg.ovf && r_reg.mask;

        // Register reads
        r_next.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_SHAPE:  r_next.rdata = {4'h0, r_reg.shape};
                ADDR_SCALE:  r_next.rdata = {2'h0, r_reg.scale};
                ADDR_ACCESS: r_next.rdata = {r_reg.trig, r_reg.dir, r_reg.ui, r_reg.sub};
                ADDR_DATA:   r_next.rdata = {1'h0, r_reg.data};
                ADDR_MASK:   r_next.rdata = {7'h00, r_reg.mask};
                ADDR_STATUS: r_next.rdata = {7'h00, r_reg.ovf};
                default:     r_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            r_reg       <= '0;
            r_reg.shape <= SHAPE_RESET;
            r_reg.scale <= SCALE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_reg_rdata  = r_reg.rdata;
    assign o_reg_rvalid = r_reg.rvalid;
    assign o_dac_code   = r_reg.dac;
    assign o_irq        = r_reg.irq;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    property p_trig_clears;
        $rose(r_reg.trig) |-> (r_reg.st == ST_ACCESS) ##1 (!r_reg.trig && (r_reg.st == ST_IDLE));
    endproperty
    a_trig_clears: assert property (p_trig_clears) else $error("Trigger not cleared");

    property p_trig_starts;
        (wr_access && i_reg_wdata[ACC_TRIG_BIT]) |=> (r_reg.st == ST_ACCESS) ##1 (r_reg.st == ST_IDLE);
    endproperty
    a_trig_starts: assert property (p_trig_starts) else $error("Access not started");

    property p_write_dir;
        (r_reg.st == ST_ACCESS) |-> (ram_if.we == !r_reg.dir) && (ram_if.addr == {r_reg.ui, r_reg.sub});
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("Wrong access direction");

    property p_read_loads;
        (r_reg.st == ST_ACCESS && r_reg.dir && arb) |=> r_reg.data == $past(ram_if.rdata);
    endproperty
    a_read_loads: assert property (p_read_loads) else $error("Read data not loaded");

    property p_rom_read;
        (r_reg.st == ST_ACCESS && r_reg.dir && !arb) |=> r_reg.data == $past(rom_val);
    endproperty
    a_rom_read: assert property (p_rom_read) else $error("Template read wrong");

    property p_ovf_set;
        (i_sample_en && over) |=> r_reg.ovf && (o_dac_code[5:0] == MAG_MAX);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("Overflow not flagged");

    property p_irq_mask;
        o_irq |-> $past(r_reg.mask) && $past(r_reg.ovf);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("Unmasked interrupt");

    property p_preset_unscaled;
        (i_sample_en && !arb && !over) |=> o_dac_code[5:0] == $past(abs_level[5:0]) && $past(level == 17'(sum));
    endproperty
    a_preset_unscaled: assert property (p_preset_unscaled) else $error("Preset scaled");

    property p_phase_reset;
        i_ui_start |=> (r_reg.phase == 4'h0);
    endproperty
    a_phase_reset: assert property (p_phase_reset) else $error("Phase not reset");

    // Register side: busy writes, field capture, reads and flags
    property p_busy_write_dropped;
        (i_reg_wr && (i_reg_addr == ADDR_ACCESS) && (r_reg.st == ST_ACCESS))
            |=> (r_reg.ui == $past(r_reg.ui)) && (r_reg.sub == $past(r_reg.sub)) && !r_reg.trig;
    endproperty
    a_busy_write_dropped: assert property (p_busy_write_dropped) else $error("Busy access write taken");

    property p_fields_taken;
        wr_access |=> {r_reg.trig, r_reg.dir, r_reg.ui, r_reg.sub} == $past(i_reg_wdata);
    endproperty
    a_fields_taken: assert property (p_fields_taken) else $error("Access fields not stored");

    property p_access_one_cycle;
        (r_reg.st == ST_ACCESS) |=> (r_reg.st == ST_IDLE) && !r_reg.trig;
    endproperty
    a_access_one_cycle: assert property (p_access_one_cycle) else $error("Access did not finish");

    property p_rvalid_pulse;
        i_reg_rd |=> o_reg_rvalid;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("Read not answered");

    property p_mask_read;
        (i_reg_rd && (i_reg_addr == ADDR_MASK))
            |=> o_reg_rdata == {7'h00, $past(r_reg.mask)};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("Mask read wrong");

    property p_status_read;
        (i_reg_rd && (i_reg_addr == ADDR_STATUS))
            |=> o_reg_rdata == {7'h00, $past(r_reg.ovf)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read wrong");

    property p_ovf_clear;
        (i_reg_rd && (i_reg_addr == ADDR_STATUS) && !(i_sample_en && over))
            |=> !r_reg.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("Overflow not cleared");

    property p_ovf_sticky;
        (r_reg.ovf && !(i_reg_rd && (i_reg_addr == ADDR_STATUS))) |=> r_reg.ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow lost");

    property p_irq_raise;
        (r_reg.ovf && r_reg.mask) |=> o_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("Enabled interrupt missing");

    // Datapath: history, phase, scaling and code form
    property p_hist_shift;
        i_ui_start |=> (r_reg.hist[0] == {$past(i_mark_neg), $past(i_mark_pos)})
            && (r_reg.hist[NUM_UI-1:1] == $past(r_reg.hist[NUM_UI-2:0]));
    endproperty
    a_hist_shift: assert property (p_hist_shift) else $error("Symbol history wrong");

    property p_phase_step;
        (i_sample_en && !i_ui_start) |=> r_reg.phase == $past(r_reg.phase) + 4'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("Sub-phase not advanced");

    property p_scale_unity;
        (arb && (r_reg.scale == SCALE_RESET)) |-> level == 17'(sum);
    endproperty
    a_scale_unity: assert property (p_scale_unity) else $error("Unity scale changed level");

    property p_no_neg_zero;
        i_sample_en |=> !(o_dac_code[6] && (o_dac_code[5:0] == 6'h00));
    endproperty
    a_no_neg_zero: assert property (p_no_neg_zero) else $error("Negative zero code");

    property p_dac_hold;
        !i_sample_en |=> $stable(o_dac_code);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("Code changed without sample");

    c_ram_write: cover property ((r_reg.st == ST_ACCESS) && !r_reg.dir && arb);
    c_ram_read:  cover property ((r_reg.st == ST_ACCESS) && r_reg.dir && arb);
    c_overflow:  cover property (i_sample_en && over && arb);
    c_irq:       cover property ($rose(o_irq));
    c_preset:    cover property (i_sample_en && !arb && !over);

endmodule

// ===== sim/tps_pulse_shaper_tb.sv
// Self-checking bench for the transmit pulse-shaping block
`timescale 1ns/100ps
module tps_pulse_shaper_tb
    import tps_pkg::*;
;
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        ui_start  = 1'b0;
    logic        sample_en = 1'b0;
    logic        mark_pos  = 1'b0;
    logic        mark_neg  = 1'b0;
    logic [6:0]  dac_code;
    logic        irq;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    logic [31:0] lfsr_reg   = 32'h0b92_42ce;
    int          mem [64];
    int          hist [4];
    logic        model_ovf  = 1'b0;

    tps_pulse_shaper tps_pulse_shaper_inst (
        .i_clk_sys(clk_sys), .i_rst(rst),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
        .i_ui_start(ui_start), .i_sample_en(sample_en), .i_mark_pos(mark_pos), .i_mark_neg(mark_neg),
        .o_dac_code(dac_code), .o_irq(irq)
    );

    always #2.5 clk_sys = ~clk_sys;

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic void rnd(output logic [31:0] v);
        lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        v = lfsr_reg;
    endfunction

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // Two writes on consecutive edges, strobe held high between them
    task automatic bus_wr2(input logic [7:0] a1, input logic [7:0] d1, input logic [7:0] a2, input logic [7:0] d2);
        @(negedge clk_sys);
        reg_addr = a1;
        reg_wdata = d1;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_addr = a2;
        reg_wdata = d2;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 4) check("rvalid", 8'h01, {7'h00, reg_rvalid});
        d = reg_rdata;
    endtask

    task automatic ram_access(input logic [5:0] idx, input logic dir, input logic [6:0] val, output logic [7:0] got);
        logic [7:0] d;
        bus_wr(ADDR_ACCESS, {2'b00, idx});
        if (!dir) bus_wr(ADDR_DATA, {1'b0, val});
        bus_wr(ADDR_ACCESS, {1'b1, dir, idx});
        for (int i = 0; i < 8; i++) begin
            bus_rd(ADDR_ACCESS, d);
            if (d[ACC_TRIG_BIT] === 1'b0) break;
        end
        check("trigger", {1'b0, dir, idx}, d);
        if (dir) bus_rd(ADDR_DATA, got);
    endtask

    function automatic int s2i(input int v);
        return v[6] ? -int'(v[5:0]) : int'(v[5:0]);
    endfunction

    task automatic send_symbol(input int m, output logic [6:0] code);
        @(negedge clk_sys);
        ui_start = 1'b1;
        mark_pos = (m == 1);
        mark_neg = (m == 2);
        @(negedge clk_sys);
        ui_start = 1'b0;
        sample_en = 1'b1;
        @(negedge clk_sys);
        sample_en = 1'b0;
        code = dac_code;
    endtask

    task automatic line_symbol(input int m, input int scale);
        int         lvl;
        logic [7:0] exp;
        logic [6:0] code;
        send_symbol(m, code);
        for (int i = 3; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = (m == 1) ? 1 : (m == 2) ? -1 : 0;
        lvl = 0;
        for (int i = 0; i < 4; i++) lvl += hist[i] * s2i(mem[i*16]);
        // Scaling floors toward minus infinity, like an arithmetic shift
        lvl = (lvl * (scale + 1)) >>> SCALE_SHIFT;
        if (lvl > 63 || lvl < -63) model_ovf = 1'b1;
        if (lvl > 63) lvl = 63;
        if (lvl < -63) lvl = -63;
        exp = (lvl < 0) ? {1'b0, 1'b1, 6'(-lvl)} : {2'b00, 6'(lvl)};
        check("dac_code", exp, {1'b0, code});
    endtask

    logic [7:0] reset_addr [7] = '{ADDR_SHAPE, ADDR_SCALE, ADDR_ACCESS, ADDR_DATA, ADDR_MASK, ADDR_STATUS, 8'h10};
    logic [7:0] reset_val  [7] = '{8'h00, {2'b00, SCALE_RESET}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [5:0] idx_list   [16];
    int         sample_set [4] = '{20, 30, 'h46, 40};

    initial begin
        logic [31:0] v;
        logic [7:0]  d;
        logic [6:0]  val;
        int          sym [4];
        logic [6:0]  code_a;
        logic [6:0]  code_b;
        foreach (mem[i]) mem[i] = 0;
        foreach (hist[i]) hist[i] = 0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        foreach (reset_addr[i]) begin
            bus_rd(reset_addr[i], d);
            check("reset value", reset_val[i], d);
        end
        rnd(v);
        bus_wr(ADDR_SHAPE, v[7:0]);
        bus_wr(ADDR_SCALE, v[15:8]);
        bus_wr(ADDR_MASK, v[23:16]);
        bus_wr(ADDR_STATUS, 8'hff);
        bus_wr(8'h10, 8'hff);
        bus_rd(ADDR_SHAPE, d);
        check("shape", {4'h0, v[3:0]}, d);
        bus_rd(ADDR_SCALE, d);
        check("scale", {2'b00, v[13:8]}, d);
        bus_rd(ADDR_MASK, d);
        check("mask", {7'h00, v[16]}, d);
        bus_rd(ADDR_STATUS, d);
        check("status write", 8'h00, d);
        bus_rd(8'h10, d);
        check("unmapped", 8'h00, d);
        bus_wr(ADDR_MASK, 8'h00);
        bus_wr(ADDR_SHAPE, 8'h0c);
        // Write everything first so a wrong index shows up on read-back
        foreach (idx_list[k]) begin
            rnd(v);
            idx_list[k] = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : v[5:0];
            val = (v[14:8] == 7'h40) ? 7'h00 : v[14:8];
            mem[idx_list[k]] = val;
            ram_access(idx_list[k], 1'b0, val, d);
        end
        foreach (idx_list[k]) begin
            ram_access(idx_list[k], 1'b1, 7'h00, d);
            check("ram read", 8'(mem[idx_list[k]]), d);
        end
        // Access register rewrite during the access must be dropped
        bus_wr(ADDR_ACCESS, 8'h21);
        bus_wr(ADDR_DATA, 8'h15);
        bus_wr2(ADDR_ACCESS, 8'ha1, ADDR_ACCESS, 8'h05);
        mem[33] = 'h15;
        bus_rd(ADDR_ACCESS, d);
        check("access busy write", 8'h21, d);
        ram_access(6'd33, 1'b1, 7'h00, d);
        check("ram read 33", 8'h15, d);
        ram_access(6'd5, 1'b1, 7'h00, d);
        check("ram read 5", 8'(mem[5]), d);
        for (int i = 0; i < 4; i++) begin
            mem[i*16] = sample_set[i];
            ram_access(6'(i*16), 1'b0, 7'(sample_set[i]), d);
        end
        for (int run = 0; run < 2; run++) begin
            bus_wr(ADDR_SCALE, run ? 8'h0f : 8'h1f);
            bus_wr(ADDR_SHAPE, run ? 8'h0f : 8'h0c);
            for (int n = 0; n < 12; n++) begin
                rnd(v);
                line_symbol((n >= 8) ? 1 : int'(v[7:0]) % 3, run ? 15 : 31);
            end
        end
        check("irq masked", 8'h00, {7'h00, irq});
        bus_wr(ADDR_MASK, 8'h01);
        repeat (2) @(negedge clk_sys);
        check("irq enabled", {7'h00, model_ovf}, {7'h00, irq});
        bus_rd(ADDR_STATUS, d);
        check("status", {7'h00, model_ovf}, d);
        bus_rd(ADDR_STATUS, d);
        check("status cleared", 8'h00, d);
        repeat (2) @(negedge clk_sys);
        check("irq cleared", 8'h00, {7'h00, irq});
        // Preset shapes: the same four symbols at two scales must match
        for (int t = 0; t < 4; t++) begin
            bus_wr(ADDR_SHAPE, {4'h0, t[0] ? PULSE_TEMPLATE_SELECT_120_OR_EXT : PULSE_TEMPLATE_SELECT_75_INTERNAL});
            bus_wr(ADDR_SCALE, 8'h3f);
            foreach (sym[j]) begin
                rnd(v);
                sym[j] = int'(v[7:0]) % 3;
                send_symbol(sym[j], code_a);
            end
            bus_wr(ADDR_SCALE, 8'h00);
            foreach (sym[j]) send_symbol(sym[j], code_b);
            check("preset code", {1'b0, code_a}, {1'b0, code_b});
        end
        // Template read in preset mode still completes the access
        ram_access(6'h12, 1'b1, 7'h00, d);
        wrap_up();
    end
endmodule
